// ==== core/crs_pkg.sv ====
// Package: register set constants, flag layout, port structs
package crs_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 20;
   localparam int PRIO_W = 3;
   localparam int FLAG_W = 11;
   localparam int SEL_W = 5;
   localparam int SWI_LAST = 31;
   localparam logic [4:0] SEL_DATA0 = 5'h00;
   localparam logic [4:0] SEL_DATA1 = 5'h01;
   localparam logic [4:0] SEL_DATA2 = 5'h02;
   localparam logic [4:0] SEL_DATA3 = 5'h03;
   localparam logic [4:0] SEL_ADDR0 = 5'h04;
   localparam logic [4:0] SEL_ADDR1 = 5'h05;
   localparam logic [4:0] SEL_FRAME = 5'h06;
   localparam logic [4:0] SEL_VTB = 5'h07;
   localparam logic [4:0] SEL_PC = 5'h08;
   localparam logic [4:0] SEL_USP = 5'h09;
   localparam logic [4:0] SEL_ISP = 5'h0A;
   localparam logic [4:0] SEL_SB = 5'h0B;
   localparam logic [4:0] SEL_FLAGS = 5'h0C;
   localparam logic [4:0] SEL_SP = 5'h0D;
   localparam logic [4:0] SEL_D0_UP = 5'h0E;
   localparam logic [4:0] SEL_D0_LO = 5'h0F;
   localparam logic [4:0] SEL_D1_UP = 5'h10;
   localparam logic [4:0] SEL_D1_LO = 5'h11;
   localparam logic [4:0] SEL_PAIR_LO = 5'h12;
   localparam logic [4:0] SEL_PAIR_HI = 5'h13;
   localparam logic [4:0] SEL_APAIR = 5'h14;
   localparam int FB_CARRY = 0;
   localparam int FB_DEBUG = 1;
   localparam int FB_ZERO = 2;
   localparam int FB_SIGN = 3;
   localparam int FB_BANK = 4;
   localparam int FB_OVF = 5;
   localparam int FB_IEN = 6;
   localparam int FB_STACK = 7;
   localparam int FB_IPL_LO = 8;
   localparam logic [10:0] FLAG_WMASK = 11'h7FF;
   localparam logic [10:0] FLAG_RST = 11'h000;
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [19:0] ADDR_RST = 20'h00000;

   typedef struct packed {
      logic carry;
      logic zero;
      logic sign;
      logic ovf;
   } crs_alu_flags_t;

   typedef struct packed {
      logic hw_accept;
      logic sw_exec;
      logic [5:0] sw_num;
   } crs_irq_evt_t;
endpackage : crs_pkg

// ==== core/crs_bank.sv ====
// One register bank: four data, two address and the frame base register
`timescale 1ns/10ps
`default_nettype none
module crs_bank #(
   parameter int W = 16
) (
   input wire logic clk, // core clock
   input wire logic rst, // async reset, high
   input wire logic [2:0] wr_idx, // register index within bank
   input wire logic [1:0] wr_be, // byte enables upper/lower
   input wire logic wr_en, // write this bank
   input wire logic [W-1:0] wr_data, // write data
   input wire logic hi_en, // second write, pair upper half
   input wire logic [2:0] hi_idx, // second write index
   input wire logic [W-1:0] hi_data, // second write data
   output logic [7*W-1:0] regs_q // all seven registers, index 0 lowest
);
   logic [W-1:0] mem_r [7];

   genvar g;
   generate
      for (g = 0; g < 7; g++)
      begin : g_reg
         wire hit_lo = wr_en && wr_idx == 3'(g);
         wire hit_hi = hi_en && hi_idx == 3'(g);
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               mem_r[g] <= '0;
            else if (hit_hi)
               mem_r[g] <= hi_data;
            else if (hit_lo)
            begin
               if (wr_be[0])
                  mem_r[g][7:0] <= wr_data[7:0];
               if (wr_be[1])
                  mem_r[g][W-1:8] <= wr_data[W-1:8];
            end
         end
         assign regs_q[g*W +: W] = mem_r[g];
      end
   endgenerate
endmodule : crs_bank
`default_nettype wire

// ==== core/crs_regset.sv ====
// Programmer-visible register set with flag word and interrupt gating
// Function
// - Thirteen visible registers, banked ones counted once
// - Data, address, frame base form one bank
// - Bank flag picks bank zero or one
// - Data regs 16-bit; first two byte-addressable
// - Data pairs form 32-bit operands
// - Address regs 16-bit, pairable as 32-bit
// - Frame base 16-bit frame-relative base
// - Vector table base 20-bit
// - Program counter 20-bit, next instruction
// - Separate 16-bit user and interrupt stack pointers
// - Stack flag 0 interrupt, 1 user
// - Static base 16-bit
// - Flag word is 11 bits
// - Carry captures ALU carry, borrow, shift-out
// - Zero flag set on zero result
// - Sign flag set on negative result
// - Overflow flag set on overflow
// - Interrupt enable gates maskable interrupts
// - Any accepted interrupt clears interrupt enable
// - Stack flag cleared on hw or low soft interrupt
// - Three-bit priority; admit only strictly higher
`timescale 1ns/10ps
`default_nettype none
module crs_regset #(
   parameter int DW = crs_pkg::DATA_W,
   parameter int AW = crs_pkg::ADDR_W
) (
   input wire logic clk, // core clock, 100 MHz
   input wire logic rst, // async reset, high
   input wire logic [4:0] reg_sel, // register select for access
   input wire logic [31:0] reg_wdata, // write data, pairs use all 32 bits
   input wire logic reg_we, // write strobe
   input wire logic reg_re, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic pc_load, // execution unit loads next PC
   input wire logic [19:0] pc_next, // next instruction address
   input wire logic alu_upd, // ALU result flags valid
   input wire crs_pkg::crs_alu_flags_t alu_flags, // ALU flag outcomes
   input wire logic irq_req, // maskable interrupt pending
   input wire logic [2:0] irq_prio, // its priority level
   input wire crs_pkg::crs_irq_evt_t irq_evt, // accept / soft interrupt event
   output logic irq_admit, // request may be accepted
   output logic bank_sel, // active bank
   output logic [15:0] sp_active, // active stack pointer
   output logic [10:0] flags_q // flag word
);
   logic [10:0] flags_r;
   logic [19:0] vtb_r;
   logic [19:0] pc_r;
   logic [15:0] usp_r;
   logic [15:0] isp_r;
   logic [15:0] sb_r;
   logic [31:0] rdata_r;
   logic [7*DW-1:0] bank0_q;
   logic [7*DW-1:0] bank1_q;

   // Register selects decoded once
   wire is_bankreg = reg_sel <= crs_pkg::SEL_FRAME;
   wire is_d0up = reg_sel == crs_pkg::SEL_D0_UP;
   wire is_d0lo = reg_sel == crs_pkg::SEL_D0_LO;
   wire is_d1up = reg_sel == crs_pkg::SEL_D1_UP;
   wire is_d1lo = reg_sel == crs_pkg::SEL_D1_LO;
   wire is_byte = is_d0up | is_d0lo | is_d1up | is_d1lo;
   wire is_plo = reg_sel == crs_pkg::SEL_PAIR_LO;
   wire is_phi = reg_sel == crs_pkg::SEL_PAIR_HI;
   wire is_apr = reg_sel == crs_pkg::SEL_APAIR;
   wire is_pair = is_plo | is_phi | is_apr;
   wire bank_flag = flags_r[crs_pkg::FB_BANK];
   wire stk_flag = flags_r[crs_pkg::FB_STACK];

   // Bank write port: low word index and byte enables
   wire [2:0] byte_idx = (is_d0up | is_d0lo) ? 3'h0 : 3'h1;
   wire [2:0] lo_idx = is_byte ? byte_idx :
      is_plo ? 3'h0 : is_phi ? 3'h1 : is_apr ? 3'h4 : reg_sel[2:0];
   wire [2:0] hi_idx = is_plo ? 3'h2 : is_phi ? 3'h3 : 3'h5;
   wire [7:0] wbyte = reg_wdata[7:0];
   wire [15:0] lo_data = is_byte ? {wbyte, wbyte} : reg_wdata[15:0];
   wire [1:0] lo_be = (is_d0up | is_d1up) ? 2'b10 :
      (is_d0lo | is_d1lo) ? 2'b01 : 2'b11;
   wire bank_wr = reg_we & (is_bankreg | is_byte | is_pair);
   wire wr_b0 = bank_wr & ~bank_flag;
   wire wr_b1 = bank_wr & bank_flag;

   // Two identical banks
   crs_bank #(.W(DW)) u_bank0 (
      .clk(clk),
      .rst(rst),
      .wr_idx(lo_idx),
      .wr_be(lo_be),
      .wr_en(wr_b0),
      .wr_data(lo_data),
      .hi_en(wr_b0 & is_pair),
      .hi_idx(hi_idx),
      .hi_data(reg_wdata[31:16]),
      .regs_q(bank0_q)
   );

   crs_bank #(.W(DW)) u_bank1 (
      .clk(clk),
      .rst(rst),
      .wr_idx(lo_idx),
      .wr_be(lo_be),
      .wr_en(wr_b1),
      .wr_data(lo_data),
      .hi_en(wr_b1 & is_pair),
      .hi_idx(hi_idx),
      .hi_data(reg_wdata[31:16]),
      .regs_q(bank1_q)
   );

   wire [7*DW-1:0] act_q = bank_flag ? bank1_q : bank0_q;
   wire [15:0] act_d0 = act_q[0*DW +: DW];
   wire [15:0] act_d1 = act_q[1*DW +: DW];
   wire [15:0] act_d2 = act_q[2*DW +: DW];
   wire [15:0] act_d3 = act_q[3*DW +: DW];
   wire [15:0] act_a0 = act_q[4*DW +: DW];
   wire [15:0] act_a1 = act_q[5*DW +: DW];
   wire [15:0] act_fb = act_q[6*DW +: DW];

   // Flag word update; hardware events take priority over software writes
   wire flag_wr = reg_we & (reg_sel == crs_pkg::SEL_FLAGS);
   wire sw_low = irq_evt.sw_exec && irq_evt.sw_num <= 6'(crs_pkg::SWI_LAST);
   wire any_accept = irq_evt.hw_accept | irq_evt.sw_exec;
   wire clr_stk = irq_evt.hw_accept | sw_low;
   wire [10:0] flag_wv = (flags_r & ~crs_pkg::FLAG_WMASK) |
      (reg_wdata[10:0] & crs_pkg::FLAG_WMASK);
   logic [10:0] flags_nxt;
   always_comb
   begin
      flags_nxt = flag_wr ? flag_wv : flags_r;
      if (alu_upd)
      begin
         flags_nxt[crs_pkg::FB_CARRY] = alu_flags.carry;
         flags_nxt[crs_pkg::FB_ZERO] = alu_flags.zero;
         flags_nxt[crs_pkg::FB_SIGN] = alu_flags.sign;
         flags_nxt[crs_pkg::FB_OVF] = alu_flags.ovf;
      end
      if (any_accept)
         flags_nxt[crs_pkg::FB_IEN] = 1'b0;
      if (clr_stk)
         flags_nxt[crs_pkg::FB_STACK] = 1'b0;
   end

   // Stack pointer select: SP alias goes to the active pointer
   wire sp_wr = reg_we & (reg_sel == crs_pkg::SEL_SP);
   wire usp_wr = (reg_we & (reg_sel == crs_pkg::SEL_USP)) | (sp_wr & stk_flag);
   wire isp_wr = (reg_we & (reg_sel == crs_pkg::SEL_ISP)) | (sp_wr & ~stk_flag);
   wire vtb_wr = reg_we & (reg_sel == crs_pkg::SEL_VTB);
   wire pc_wr = reg_we & (reg_sel == crs_pkg::SEL_PC);
   wire sb_wr = reg_we & (reg_sel == crs_pkg::SEL_SB);
   // Execution unit PC load wins over a software write in the same cycle
   wire [19:0] pc_nxt = pc_load ? pc_next : pc_wr ? reg_wdata[19:0] : pc_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         flags_r <= crs_pkg::FLAG_RST;
         pc_r <= crs_pkg::ADDR_RST;
      end
      else
      begin
         flags_r <= flags_nxt;
         pc_r <= pc_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         vtb_r <= crs_pkg::ADDR_RST;
      else if (vtb_wr)
         vtb_r <= reg_wdata[19:0];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         usp_r <= crs_pkg::DATA_RST;
         isp_r <= crs_pkg::DATA_RST;
      end
      else
      begin
         if (usp_wr)
            usp_r <= reg_wdata[15:0];
         if (isp_wr)
            isp_r <= reg_wdata[15:0];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sb_r <= crs_pkg::DATA_RST;
      else if (sb_wr)
         sb_r <= reg_wdata[15:0];
   end

   // Read mux; thirteen distinct registers plus their aliases
   logic [31:0] rd_mux;
   always_comb
   begin
      unique case (reg_sel)
         crs_pkg::SEL_DATA0: rd_mux = {16'h0000, act_d0};
         crs_pkg::SEL_DATA1: rd_mux = {16'h0000, act_d1};
         crs_pkg::SEL_DATA2: rd_mux = {16'h0000, act_d2};
         crs_pkg::SEL_DATA3: rd_mux = {16'h0000, act_d3};
         crs_pkg::SEL_ADDR0: rd_mux = {16'h0000, act_a0};
         crs_pkg::SEL_ADDR1: rd_mux = {16'h0000, act_a1};
         crs_pkg::SEL_FRAME: rd_mux = {16'h0000, act_fb};
         crs_pkg::SEL_VTB: rd_mux = {12'h000, vtb_r};
         crs_pkg::SEL_PC: rd_mux = {12'h000, pc_r};
         crs_pkg::SEL_USP: rd_mux = {16'h0000, usp_r};
         crs_pkg::SEL_ISP: rd_mux = {16'h0000, isp_r};
         crs_pkg::SEL_SB: rd_mux = {16'h0000, sb_r};
         crs_pkg::SEL_FLAGS: rd_mux = {21'h000000, flags_r};
         crs_pkg::SEL_SP: rd_mux = {16'h0000, sp_active};
         crs_pkg::SEL_D0_UP: rd_mux = {24'h000000, act_d0[15:8]};
         crs_pkg::SEL_D0_LO: rd_mux = {24'h000000, act_d0[7:0]};
         crs_pkg::SEL_D1_UP: rd_mux = {24'h000000, act_d1[15:8]};
         crs_pkg::SEL_D1_LO: rd_mux = {24'h000000, act_d1[7:0]};
         crs_pkg::SEL_PAIR_LO: rd_mux = {act_d2, act_d0};
         crs_pkg::SEL_PAIR_HI: rd_mux = {act_d3, act_d1};
         crs_pkg::SEL_APAIR: rd_mux = {act_a1, act_a0};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Read data holds for exactly the cycle after the strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_r <= 32'h00000000;
      else
         rdata_r <= reg_re ? rd_mux : 32'h00000000;
   end

   assign reg_rdata = rdata_r;
   assign sp_active = stk_flag ? usp_r : isp_r;
   assign bank_sel = bank_flag;
   assign flags_q = flags_r;
   // Debug flag is passed through untouched; software keeps it clear
   assign irq_admit = irq_req & flags_r[crs_pkg::FB_IEN] &
      (irq_prio > flags_r[crs_pkg::FB_IPL_LO +: crs_pkg::PRIO_W]);
endmodule : crs_regset
`default_nettype wire

// ==== testbench/crs_regset_chk.sv ====
// Checker: port-level assertions for the register set
`timescale 1ns/10ps
`default_nettype none
module crs_regset_chk (
   input wire logic clk, // core clock
   input wire logic rst, // async reset
   input wire logic [4:0] reg_sel, // select
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_we, // write strobe
   input wire logic reg_re, // read strobe
   input wire logic [31:0] reg_rdata, // read data
   input wire logic pc_load, // PC load
   input wire logic [19:0] pc_next, // next PC
   input wire logic alu_upd, // ALU update
   input wire crs_pkg::crs_alu_flags_t alu_flags, // ALU flags
   input wire logic irq_req, // request
   input wire logic [2:0] irq_prio, // its level
   input wire crs_pkg::crs_irq_evt_t irq_evt, // events
   input wire logic irq_admit, // admit
   input wire logic bank_sel, // bank
   input wire logic [15:0] sp_active, // active SP
   input wire logic [10:0] flags_q // flags
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire logic evt;
   assign evt = irq_evt.hw_accept | irq_evt.sw_exec;
   AST_ADMIT: assert property (irq_admit == (irq_req & flags_q[6] & (irq_prio > flags_q[10:8])))
      else $error("admit does not follow enable and level");
   AST_IEN_CLR: assert property (evt |=> !flags_q[6])
      else $error("enable not cleared on accept");
   AST_STK_CLR: assert property (irq_evt.hw_accept || (irq_evt.sw_exec && irq_evt.sw_num <= 6'd31) |=> !flags_q[7])
      else $error("stack select not cleared");
   AST_BANK: assert property (bank_sel == flags_q[4])
      else $error("bank output differs from flag");
   AST_ALU: assert property (alu_upd |=> {flags_q[0], flags_q[2], flags_q[3], flags_q[5]} == $past(alu_flags))
      else $error("ALU flags not captured");
   AST_FLGWR: assert property (reg_we && reg_sel == crs_pkg::SEL_FLAGS && !alu_upd && !evt |=> flags_q == $past(reg_wdata[10:0]))
      else $error("flag write lost");
   AST_PC: assert property (pc_load ##1 (reg_re && reg_sel == crs_pkg::SEL_PC) |=> reg_rdata[19:0] == $past(pc_next, 2))
      else $error("PC load not read back");
   AST_SP: assert property (reg_re && reg_sel == crs_pkg::SEL_SP |=> reg_rdata[15:0] == $past(sp_active))
      else $error("active stack pointer read wrong");
   COV_ADMIT: cover property (irq_admit);
   COV_SWHI: cover property (irq_evt.sw_exec && irq_evt.sw_num == 6'd32);
   COV_PAIR: cover property (reg_re && reg_sel == crs_pkg::SEL_PAIR_HI);
endmodule : crs_regset_chk
bind crs_regset crs_regset_chk u_crs_regset_chk (.clk, .rst, .reg_sel, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
   .pc_load, .pc_next, .alu_upd, .alu_flags, .irq_req, .irq_prio, .irq_evt, .irq_admit, .bank_sel, .sp_active, .flags_q);
`default_nettype wire

// ==== testbench/crs_exec_model.sv ====
// Execution unit model: ALU flag outcomes and PC loads
`timescale 1ns/10ps
`default_nettype none
module crs_exec_model (
   input wire logic clk, // core clock
   input wire logic rst, // async reset
   input wire logic go, // run one add
   input wire logic [15:0] op_a, // first operand
   input wire logic [15:0] op_b, // second operand
   output logic alu_upd, // flags valid
   output var crs_pkg::crs_alu_flags_t alu_flags, // flag outcomes
   output logic pc_load, // load PC
   output logic [19:0] pc_next // next PC
);
   logic [16:0] sum;
   assign sum = {1'b0, op_a} + {1'b0, op_b};
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         alu_upd <= 1'b0;
         pc_load <= 1'b0;
         alu_flags <= '0;
         pc_next <= '0;
      end
      else if (go)
      begin
         alu_upd <= 1'b1;
         pc_load <= 1'b1;
         pc_next <= {4'h5, op_a};
         alu_flags.carry <= sum[16];
         alu_flags.zero <= sum[15:0] == 16'h0;
         alu_flags.sign <= sum[15];
         alu_flags.ovf <= (op_a[15] == op_b[15]) && (sum[15] != op_a[15]);
      end
      else
      begin
         // Idle values keep toggling so a design that ignores the strobes shows it
         alu_upd <= 1'b0;
         pc_load <= 1'b0;
         alu_flags <= ~alu_flags;
         pc_next <= ~pc_next;
      end
   end
endmodule : crs_exec_model
`default_nettype wire

// ==== testbench/crs_regset_bench.sv ====
// Bench: register set driven by register port, execution model and events
`timescale 1ns/10ps
`default_nettype none
module crs_regset_bench;
   logic clk, rst, reg_we, reg_re, go, irq_req, pc_load, alu_upd, irq_admit, bank_sel;
   logic [4:0] reg_sel;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic [15:0] op_a, op_b, sp_active;
   logic [19:0] pc_next;
   logic [2:0] irq_prio;
   logic [10:0] flags_q;
   crs_pkg::crs_alu_flags_t alu_flags;
   crs_pkg::crs_irq_evt_t irq_evt;
   int err_count, checks_done;
   logic [31:0] sh [0:1][0:11];
   crs_regset u_crs_regset (.clk, .rst, .reg_sel, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .pc_load, .pc_next,
      .alu_upd, .alu_flags, .irq_req, .irq_prio, .irq_evt, .irq_admit, .bank_sel, .sp_active, .flags_q);
   crs_exec_model u_crs_exec_model (.clk, .rst, .go, .op_a, .op_b, .alu_upd, .alu_flags, .pc_load, .pc_next);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] s, input logic [31:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_sel <= s;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask : wr
   task automatic rc(input logic [4:0] s, input logic [31:0] exp);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_sel <= s;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rc
   task automatic pr(input logic [4:0] p, input logic [4:0] h, input logic [4:0] l);
      logic [31:0] w;
      w = $urandom;
      wr(p, w);
      rc(h, 32'(w[31:16]));
      rc(l, 32'(w[15:0]));
      rc(p, w);
   endtask : pr
   task automatic alu(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      @(posedge clk);
      go <= 1'b1;
      op_a <= a;
      op_b <= b;
      @(posedge clk);
      go <= 1'b0;
      rc(crs_pkg::SEL_PC, {12'h005, a});
      chk(32'({flags_q[0], flags_q[2], flags_q[3], flags_q[5]}),
         32'({s[16], s[15:0] == 16'h0, s[15], (a[15] == b[15]) && (s[15] != a[15])}));
   endtask : alu
   task automatic ev(input crs_pkg::crs_irq_evt_t e, input logic [1:0] want);
      wr(crs_pkg::SEL_FLAGS, 32'h0C0);
      @(posedge clk);
      irq_evt <= e;
      @(posedge clk);
      irq_evt <= '0;
      #1 chk(32'(flags_q[7:6]), 32'(want));
   endtask : ev
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   initial
   begin
      #500000;
      err_count++;
      final_report();
   end
   initial
   begin
      {reg_we, reg_re, go, irq_req, reg_sel, reg_wdata, op_a, op_b, irq_prio, irq_evt} = '0;
      err_count = 0;
      checks_done = 0;
      v = $urandom(72967);
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int s = 0; s < 32; s++)
      begin
         if (s > 20)
            wr(5'(s), $urandom);
         rc(5'(s), 32'h0);
      end
      $display("test reset and unmapped done");
      for (int b = 0; b < 2; b++)
      begin
         wr(crs_pkg::SEL_FLAGS, 32'(b) << 4);
         for (int s = 0; s < 12; s++)
         begin
            v = $urandom;
            wr(5'(s), v);
            sh[b][s] = v & ((s == 7 || s == 8) ? 32'hFFFFF : 32'hFFFF);
            if (s > 6)
               sh[0][s] = sh[b][s];
         end
      end
      for (int b = 0; b < 2; b++)
      begin
         wr(crs_pkg::SEL_FLAGS, 32'(b) << 4);
         #1 chk(32'(bank_sel), 32'(b));
         for (int s = 0; s < 12; s++)
            rc(5'(s), sh[b][s]);
      end
      $display("test banks done");
      wr(crs_pkg::SEL_DATA0, 32'h1234);
      wr(crs_pkg::SEL_D0_LO, 32'hFFAB);
      rc(crs_pkg::SEL_DATA0, 32'h12AB);
      wr(crs_pkg::SEL_D0_UP, 32'h00CD);
      rc(crs_pkg::SEL_DATA0, 32'hCDAB);
      rc(crs_pkg::SEL_D0_UP, 32'h00CD);
      wr(crs_pkg::SEL_DATA1, 32'h5678);
      wr(crs_pkg::SEL_D1_UP, 32'hFF99);
      rc(crs_pkg::SEL_DATA1, 32'h9978);
      wr(crs_pkg::SEL_D1_LO, 32'h0042);
      rc(crs_pkg::SEL_D1_LO, 32'h0042);
      rc(crs_pkg::SEL_D1_UP, 32'h0099);
      pr(crs_pkg::SEL_PAIR_LO, crs_pkg::SEL_DATA2, crs_pkg::SEL_DATA0);
      pr(crs_pkg::SEL_PAIR_HI, crs_pkg::SEL_DATA3, crs_pkg::SEL_DATA1);
      pr(crs_pkg::SEL_APAIR, crs_pkg::SEL_ADDR1, crs_pkg::SEL_ADDR0);
      $display("test bytes and pairs done");
      wr(crs_pkg::SEL_USP, 32'hBEEF);
      wr(crs_pkg::SEL_ISP, 32'h1357);
      for (int u = 0; u < 2; u++)
      begin
         wr(crs_pkg::SEL_FLAGS, 32'(u) << 7);
         rc(crs_pkg::SEL_SP, (u == 1) ? 32'hBEEF : 32'h1357);
         chk(32'(sp_active), (u == 1) ? 32'hBEEF : 32'h1357);
      end
      // User pointer is active now, so the alias write must land there
      wr(crs_pkg::SEL_SP, 32'h2468);
      rc(crs_pkg::SEL_USP, 32'h2468);
      rc(crs_pkg::SEL_ISP, 32'h1357);
      $display("test stack select done");
      alu(16'hFFFF, 16'h0001);
      alu(16'h7FFF, 16'h0001);
      alu(16'h8000, 16'h8000);
      repeat (20) alu(16'($urandom), 16'($urandom));
      $display("test alu flags done");
      repeat (32)
      begin
         v = $urandom;
         wr(crs_pkg::SEL_FLAGS, {21'h0, v[10:8], 1'b0, v[6], 6'h0});
         @(posedge clk);
         irq_prio <= v[2:0];
         irq_req <= v[3];
         #1 chk(32'(irq_admit), 32'(v[3] & v[6] & (v[2:0] > v[10:8])));
      end
      $display("test admission done");
      ev(8'h80, 2'b00);
      ev(8'h60, 2'b10);
      ev(8'h5F, 2'b00);
      $display("test interrupt events done");
      // Second reset in mid-run: state must return to its reset values
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc(crs_pkg::SEL_USP, 32'h0);
      chk(32'(flags_q), 32'h0);
      $display("test mid-run reset done");
      final_report();
   end
endmodule : crs_regset_bench
`default_nettype wire
